// file: rtl/qdc_pkg.sv
// Behaviour
// - Manual-span read of active span shows strap
// - Power-up span code is 0000
// - Power-up clears all channel registers
// - Manual span loads strap on first update
// - Clear zeroes every active register
// - Clear leaves input registers intact
// - Clear during open frame aborts instruction
// - Host checks buffers after aborted instruction
// - Integrity flag low until valid update
// - Span command, address 1111 writes all
// - Code command writes sixteen data bits
// - Update command copies code and span
// - Span read: zeros then four span bits
// - Rolling readback shows previously written register
// - Update pin pulse equals update-all command
// - Command, address, data, MSB first, rising edges
// - Thirty-two bit frames lead with zeros
// - Update pin ignored while frame open
package qdc_pkg;
  localparam int NCH = 4;
  localparam int CMD_W = 4;
  localparam int DATA_W = 16;
  localparam int SPAN_W = 4;
  localparam int FRAME_W = 24;
  localparam int LONG_W = 32;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] HDR_BITS = 6'h08;
  localparam logic [3:0] CMD_WSPAN = 4'h2;
  localparam logic [3:0] CMD_WCODE = 4'h3;
  localparam logic [3:0] CMD_UPD = 4'h4;
  localparam logic [3:0] CMD_UPD_ALL = 4'h5;
  localparam logic [3:0] CMD_WSPAN_UPD = 4'h6;
  localparam logic [3:0] CMD_WCODE_UPD = 4'h7;
  localparam logic [3:0] CMD_WSPAN_UALL = 4'h8;
  localparam logic [3:0] CMD_WCODE_UALL = 4'h9;
  localparam logic [3:0] CMD_RD_ISPAN = 4'ha;
  localparam logic [3:0] CMD_RD_ICODE = 4'hb;
  localparam logic [3:0] CMD_RD_ASPAN = 4'hc;
  localparam logic [3:0] CMD_RD_ACODE = 4'hd;
  localparam logic [3:0] CMD_NOP = 4'hf;
  localparam logic [3:0] ADDR_ALL = 4'hf;
  localparam logic [3:0] SPAN_RESET = 4'h0;
  localparam logic [15:0] CODE_RESET = 16'h0000;
  // Readback pointer kinds
  localparam logic [1:0] PTR_ISPAN = 2'h0;
  localparam logic [1:0] PTR_ICODE = 2'h1;
  localparam logic [1:0] PTR_ASPAN = 2'h2;
  localparam logic [1:0] PTR_ACODE = 2'h3;
  // Host controller register offsets (Wishbone byte addresses)
  localparam logic [3:0] HREG_CMD = 4'h0;
  localparam logic [3:0] HREG_CTRL = 4'h4;
  localparam logic [3:0] HREG_RDATA = 4'h8;
  localparam logic [3:0] HREG_STAT = 4'hc;
  localparam logic [3:0] HREG_MASK = 4'h0;
  localparam int HDIV = 4;
  localparam int ASYNC_UPDATE_N_LOW = 8;
  typedef enum logic [3:0] {
    H_IDLE = 4'h1, H_LO = 4'h2, H_HI = 4'h4, H_END = 4'h8
  } qdc_hstate_type;
endpackage : qdc_pkg

// file: rtl/qdc_link_if.sv
`timescale 1ns/100ps
interface qdc_link_if;
  logic sclk;
  logic frame_select_load_n;
  logic serial_in;
  logic readback_out;
  logic readback_oe;
  logic async_update_n;
  logic system_clear_n;
  logic integrity_flag_n;
  modport device (
    input sclk, frame_select_load_n, serial_in, async_update_n,
    input system_clear_n,
    output readback_out, readback_oe, integrity_flag_n
  );
  modport host (
    output sclk, frame_select_load_n, serial_in, async_update_n,
    output system_clear_n,
    input readback_out, readback_oe, integrity_flag_n
  );
endinterface : qdc_link_if

// file: rtl/qdc_sync.sv
`timescale 1ns/100ps
module qdc_sync #(parameter int W = 1) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Sync reset
  input wire logic [W-1:0] d_i, // Async inputs
  input wire logic [W-1:0] rst_val_i, // Constant idle level
  output logic [W-1:0] q_o // Synchronised
);
  logic [W-1:0] s1_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg <= '0;
      q_o <= '0;
    end else begin
      s1_reg <= d_i ^ rst_val_i;
      q_o <= s1_reg;
    end
  end
endmodule : qdc_sync

// file: rtl/qdc_device.sv
`timescale 1ns/100ps
module qdc_device import qdc_pkg::*; (
  input wire logic clk_i, // 100 MHz clock
  input wire logic rst_i, // Power-on reset, sync high
  input wire logic manual_span_i, // Strapped manual span mode
  input wire logic [SPAN_W-1:0] strap_span_i, // Strapped span code
  input wire logic supply_low_i, // Supply dip indication
  qdc_link_if.device link, // Serial link
  output logic [NCH*DATA_W-1:0] active_code_o, // Active codes
  output logic [NCH*SPAN_W-1:0] active_span_o // Active spans
);
  logic [4:0] sy;
  logic sclk_s, cs_s, sdi_s, async_update_n_s, clr_s;
  logic sclk_d_reg, async_update_n_d_reg;
  logic [LONG_W-1:0] sh_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [SPAN_W-1:0] ispan_reg [NCH];
  logic [DATA_W-1:0] icode_reg [NCH];
  logic [SPAN_W-1:0] aspan_reg [NCH];
  logic [DATA_W-1:0] acode_reg [NCH];
  logic [1:0] ptr_kind_reg;
  logic [1:0] ptr_ch_reg;
  logic [DATA_W-1:0] rb_reg;
  logic cs_d_reg, aborted_reg;
  logic sclk_rise, sclk_fall, frame_end, async_update_n_fire;
  logic [3:0] cmd, adr;
  logic [DATA_W-1:0] dat;
  logic upd_one, upd_all, wr_span, wr_code, is_read;
  logic [1:0] hdr_kind, hdr_ch;
  logic rb_load;

  // Inverted at the input so reset drives idle-high pins to 1
  qdc_sync #(.W(5)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({link.sclk, link.frame_select_load_n, link.serial_in,
          link.async_update_n, link.system_clear_n}),
    .rst_val_i(5'h0f),
    .q_o(sy)
  );
  assign sclk_s = sy[4];
  assign cs_s = ~sy[3];
  assign sdi_s = ~sy[2];
  assign async_update_n_s = ~sy[1];
  assign clr_s = ~sy[0];

  function automatic logic [1:0] chan(input logic [3:0] a);
    // All-channels address reads back as channel A
    chan = (a == ADDR_ALL) ? 2'h0 : a[2:1];
  endfunction : chan

  function automatic logic hit(input logic [3:0] a, input int c);
    hit = (a == ADDR_ALL) || (a[2:1] == c[1:0]);
  endfunction : hit

  function automatic logic is_rd(input logic [3:0] c);
    is_rd = c[3] && (c[2] || c[1]) && c != CMD_NOP;
  endfunction : is_rd

  assign sclk_rise = sclk_s & ~sclk_d_reg;
  assign sclk_fall = ~sclk_s & sclk_d_reg;
  assign cmd = sh_reg[23:20];
  assign adr = sh_reg[19:16];
  assign dat = sh_reg[15:0];
  assign frame_end = cs_s & ~cs_d_reg & ~aborted_reg & clr_s &
    ((cnt_reg == 6'(FRAME_W)) ||
     (cnt_reg == 6'(LONG_W) && sh_reg[31:24] == 8'h00));
  // update pin locked out in frame
  assign async_update_n_fire = ~async_update_n_s & async_update_n_d_reg & cs_s;
  assign wr_span = frame_end && (cmd == CMD_WSPAN ||
    cmd == CMD_WSPAN_UPD || cmd == CMD_WSPAN_UALL);
  assign wr_code = frame_end && (cmd == CMD_WCODE ||
    cmd == CMD_WCODE_UPD || cmd == CMD_WCODE_UALL);
  assign upd_one = frame_end && (cmd == CMD_UPD ||
    cmd == CMD_WSPAN_UPD || cmd == CMD_WCODE_UPD);
  // update pin same as update all
  assign upd_all = async_update_n_fire || (frame_end && (cmd == CMD_UPD_ALL ||
    cmd == CMD_WSPAN_UALL || cmd == CMD_WCODE_UALL));
  assign is_read = is_rd(cmd);
  // Header sits in the low byte when the readback word is chosen
  assign hdr_kind = is_rd(sh_reg[7:4]) ? sh_reg[5:4] + 2'h2 : ptr_kind_reg;
  assign hdr_ch = is_rd(sh_reg[7:4]) ? chan(sh_reg[3:0]) : ptr_ch_reg;
  // A zero first byte may be a long-frame prefix: choose again later
  assign rb_load = sclk_fall && (cnt_reg == HDR_BITS ||
    (cnt_reg == HDR_BITS + HDR_BITS && sh_reg[15:8] == 8'h00));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_d_reg <= 1'b0;
      async_update_n_d_reg <= 1'b1;
      cs_d_reg <= 1'b1;
    end else begin
      sclk_d_reg <= sclk_s;
      async_update_n_d_reg <= async_update_n_s;
      cs_d_reg <= cs_s;
    end
  end

  // shift on rising edges while frame open
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_reg <= '0;
      cnt_reg <= '0;
      aborted_reg <= 1'b0;
    end else if (cs_s) begin
      cnt_reg <= '0;
      aborted_reg <= 1'b0;
    end else begin
      if (!clr_s) aborted_reg <= 1'b1;
      if (sclk_rise) begin
        sh_reg <= {sh_reg[LONG_W-2:0], sdi_s};
        if (cnt_reg != 6'(LONG_W + 1)) cnt_reg <= cnt_reg + 6'h01;
      end
    end
  end

  generate
    for (genvar c = 0; c < NCH; c++) begin : g_ch
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ispan_reg[c] <= SPAN_RESET;
          icode_reg[c] <= CODE_RESET;
        end else begin
          if (wr_span && hit(adr, c)) ispan_reg[c] <= dat[SPAN_W-1:0];
          if (wr_code && hit(adr, c)) icode_reg[c] <= dat;
        end
      end
      always_ff @(posedge clk_i) begin
        if (rst_i || !clr_s) begin
          acode_reg[c] <= CODE_RESET;
          aspan_reg[c] <= SPAN_RESET;
        end else if (upd_all || (upd_one && hit(adr, c))) begin
          acode_reg[c] <= (wr_code && hit(adr, c)) ? dat : icode_reg[c];
          // manual span takes strap at update
          aspan_reg[c] <= manual_span_i ? strap_span_i :
            (wr_span && hit(adr, c)) ? dat[SPAN_W-1:0] : ispan_reg[c];
        end
      end
      assign active_code_o[c*DATA_W +: DATA_W] = acode_reg[c];
      assign active_span_o[c*SPAN_W +: SPAN_W] = aspan_reg[c];
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i || !clr_s) begin
      ptr_kind_reg <= PTR_ASPAN;
      ptr_ch_reg <= 2'h0;
    end else if (frame_end) begin
      ptr_ch_reg <= chan(adr);
      case (cmd)
        CMD_WSPAN, CMD_RD_ISPAN: ptr_kind_reg <= PTR_ISPAN;
        CMD_WCODE, CMD_RD_ICODE: ptr_kind_reg <= PTR_ICODE;
        CMD_UPD, CMD_WSPAN_UPD, CMD_WSPAN_UALL, CMD_RD_ASPAN:
          ptr_kind_reg <= PTR_ASPAN;
        CMD_UPD_ALL: begin
          ptr_kind_reg <= PTR_ACODE;
          ptr_ch_reg <= 2'h0;
        end
        default: ptr_kind_reg <= PTR_ACODE;
      endcase
    end
  end

  // Readback shifter: load after header, shift on falling edges
  always_ff @(posedge clk_i) begin
    if (rst_i || cs_s) begin
      rb_reg <= '0;
    end else if (rb_load) begin
      case (hdr_kind)
        PTR_ISPAN:
          rb_reg <= {12'h000, ispan_reg[hdr_ch]};
        PTR_ICODE:
          rb_reg <= icode_reg[hdr_ch];
        PTR_ASPAN:
          // manual mode reports span in force
          rb_reg <= {12'h000, manual_span_i ? strap_span_i :
            aspan_reg[hdr_ch]};
        default:
          rb_reg <= acode_reg[hdr_ch];
      endcase
    end else if (sclk_fall && cnt_reg > HDR_BITS) begin
      rb_reg <= {rb_reg[DATA_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link.readback_out <= 1'b0;
      link.readback_oe <= 1'b0;
    end else begin
      link.readback_oe <= ~cs_s;
      link.readback_out <= ~cs_s & (cnt_reg >= HDR_BITS) & rb_reg[DATA_W-1];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !clr_s || supply_low_i) link.integrity_flag_n <= 1'b0;
    else if (upd_all || upd_one) link.integrity_flag_n <= 1'b1;
  end
endmodule : qdc_device

// file: rtl/qdc_host.sv
`timescale 1ns/100ps
module qdc_host import qdc_pkg::*; (
  input wire logic clk_i, // 100 MHz clock
  input wire logic rst_i, // Sync reset, high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [3:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte selects
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  output logic irq_o, // Interrupt level
  qdc_link_if.host link // Serial link
);
  qdc_hstate_type st_reg;
  logic [LONG_W-1:0] tx_reg;
  logic [DATA_W-1:0] rx_reg;
  logic [CNT_W-1:0] bit_reg;
  logic [7:0] div_reg;
  logic long_reg, busy;
  logic [3:0] ctrl_reg;
  logic [1:0] stat_reg, mask_reg;
  logic [1:0] pin_s;
  logic rb_s, flag_s;
  logic go, wr, done_ev, flag_ev, flag_d_reg;
  logic [CNT_W-1:0] nbits;

  qdc_sync #(.W(2)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({link.readback_out, link.integrity_flag_n}),
    .rst_val_i(2'h0),
    .q_o(pin_s)
  );
  assign rb_s = pin_s[1];
  assign flag_s = pin_s[0];
  assign busy = (st_reg != H_IDLE);
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign go = wr && wb_adr_i == HREG_CMD && wb_sel_i[0] && !busy;
  assign nbits = long_reg ? 6'(LONG_W) : 6'(FRAME_W);
  assign done_ev = (st_reg == H_END);
  assign flag_ev = ~flag_s & flag_d_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) wb_ack_o <= 1'b0;
    else wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else begin
      case (wb_adr_i)
        HREG_CTRL: wb_dat_o <= {28'h0, ctrl_reg};
        HREG_RDATA: wb_dat_o <= {15'h0, busy, rx_reg};
        HREG_STAT: wb_dat_o <= {14'h0, mask_reg, 13'h0, flag_s, stat_reg};
        default: wb_dat_o <= '0;
      endcase
    end
  end

  // Control: bit0 long frame, bit1 update pulse, bit2 clear pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= 4'h0;
      mask_reg <= 2'h0;
    end else if (wr && wb_adr_i == HREG_CTRL && wb_sel_i[0]) begin
      ctrl_reg <= wb_dat_i[3:0];
    end else if (wr && wb_adr_i == HREG_STAT && wb_sel_i[2]) begin
      mask_reg <= wb_dat_i[17:16];
    end else begin
      ctrl_reg[1] <= 1'b0;
    end
  end

  // Sticky status; set wins over write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_reg <= 2'h0;
      flag_d_reg <= 1'b0;
    end else begin
      flag_d_reg <= flag_s;
      stat_reg <= (stat_reg & ~((wr && wb_adr_i == HREG_STAT &&
        wb_sel_i[0]) ? wb_dat_i[1:0] : 2'h0)) | {flag_ev, done_ev};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) irq_o <= 1'b0;
    else irq_o <= |(stat_reg & ~mask_reg);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= H_IDLE;
      tx_reg <= '0;
      rx_reg <= '0;
      bit_reg <= '0;
      div_reg <= '0;
      long_reg <= 1'b0;
      link.sclk <= 1'b0;
      link.frame_select_load_n <= 1'b1;
      link.serial_in <= 1'b0;
    end else begin
      case (st_reg)
        H_IDLE: begin
          if (go) begin
            long_reg <= ctrl_reg[0];
            tx_reg <= {8'h00, wb_dat_i[23:0]};
            if (!ctrl_reg[0]) tx_reg <= {wb_dat_i[23:0], 8'h00};
            bit_reg <= '0;
            div_reg <= '0;
            link.frame_select_load_n <= 1'b0;
            st_reg <= H_LO;
          end
        end
        // data set while clock low, MSB first
        H_LO: begin
          link.serial_in <= tx_reg[LONG_W-1];
          div_reg <= div_reg + 8'h01;
          if (div_reg == 8'(HDIV - 1)) begin
            div_reg <= '0;
            link.sclk <= 1'b1;
            tx_reg <= {tx_reg[LONG_W-2:0], 1'b0};
            st_reg <= H_HI;
          end
        end
        H_HI: begin
          div_reg <= div_reg + 8'h01;
          if (div_reg == 8'(HDIV - 1)) begin
            div_reg <= '0;
            link.sclk <= 1'b0;
            // Sampled late: the far end's sync delay eats the low phase
            rx_reg <= {rx_reg[DATA_W-2:0], rb_s};
            bit_reg <= bit_reg + 6'h01;
            st_reg <= (bit_reg + 6'h01 == nbits) ? H_END : H_LO;
          end
        end
        H_END: begin
          link.frame_select_load_n <= 1'b1;
          st_reg <= H_IDLE;
        end
        default: st_reg <= H_IDLE;
      endcase
    end
  end

  // update pulse only with frame closed; host rereads via software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link.async_update_n <= 1'b1;
      link.system_clear_n <= 1'b1;
    end else begin
      link.async_update_n <= ~(ctrl_reg[1] & ~busy);
      link.system_clear_n <= ~ctrl_reg[2];
    end
  end
endmodule : qdc_host

// file: bench/qdc_link_asserts.sv
`timescale 1ns/100ps
module qdc_link_asserts (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Sync reset
  input wire logic sclk, // Link clock
  input wire logic frame_select_load_n, // Frame select
  input wire logic serial_in, // Host data
  input wire logic readback_out, // Device data
  input wire logic readback_oe, // Device drives readback
  input wire logic async_update_n, // Update pin
  input wire logic system_clear_n, // Clear pin
  input wire logic integrity_flag_n // Integrity flag
);
  logic sclk_reg;
  logic [5:0] nbits_reg;
  logic [3:0] since_reg;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_reg <= 1'b0;
    end else begin
      sclk_reg <= sclk;
    end
  end

  // Count resets while idle, so the close edge still sees the full count
  always_ff @(posedge clk_i) begin
    if (rst_i || frame_select_load_n) begin
      nbits_reg <= 6'h00;
    end else if (sclk && !sclk_reg) begin
      nbits_reg <= nbits_reg + 6'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      since_reg <= 4'hf;
    end else if ($rose(frame_select_load_n) || $rose(async_update_n)) begin
      since_reg <= 4'h0;
    end else if (since_reg != 4'hf) begin
      since_reg <= since_reg + 4'h1;
    end
  end

  sequence frame_close;
    $rose(frame_select_load_n);
  endsequence

  sequence frame_open_long;
    !frame_select_load_n && !$past(frame_select_load_n, 4);
  endsequence

  frame_len_a: assert property (frame_close |->
    nbits_reg == 6'h18 || nbits_reg == 6'h20)
    else $error("frame closed with wrong bit count");
  oe_idle_a: assert property (frame_select_load_n &&
    $past(frame_select_load_n, 4) |-> !readback_oe)
    else $error("readback driven while idle");
  oe_frame_a: assert property (frame_open_long |-> readback_oe)
    else $error("readback not driven in frame");
  sclk_idle_a: assert property (frame_select_load_n &&
    $past(frame_select_load_n, 2) |-> !sclk)
    else $error("link clock moves while idle");
  data_stable_a: assert property (!frame_select_load_n &&
    $rose(sclk) |-> $stable(serial_in))
    else $error("serial data changes at clock rise");
  lead_zero_a: assert property (!frame_select_load_n && readback_oe &&
    nbits_reg < 6'h08 |-> !readback_out)
    else $error("readback not low before data");
  update_lock_a: assert property (!async_update_n |->
    frame_select_load_n)
    else $error("update pin pulsed in open frame");
  flag_init_a: assert property ($fell(rst_i) |-> !integrity_flag_n)
    else $error("flag not low after reset");
  flag_clear_a: assert property (!system_clear_n |->
    ##[1:4] !integrity_flag_n)
    else $error("flag not low after clear");
  flag_cause_a: assert property ($rose(integrity_flag_n) |->
    since_reg < 4'h8)
    else $error("flag rose without an update");
endmodule : qdc_link_asserts

// file: bench/quad_dac_command_reset_control_tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  n_errors++; $display("unexpected %s exp %0h got %0h", n, e, g); end end
module quad_dac_command_reset_control_tb_top import qdc_pkg::*;;
  localparam logic [63:0] EXP_CODE = 64'h8000_8000_8000_0000;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic ack;
  logic irq;
  logic man = 1'b0;
  logic low = 1'b0;
  logic [3:0] strap = 4'h0;
  logic [63:0] acode;
  logic [15:0] aspan;
  int n_errors = 0;
  int total_checks = 0;

  always #5 clk_i = ~clk_i;

  qdc_link_if u_qdc_link_if ();

  qdc_host u_qdc_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq),
    .link(u_qdc_link_if));

  qdc_device u_qdc_device (.clk_i(clk_i), .rst_i(rst_i),
    .manual_span_i(man), .strap_span_i(strap), .supply_low_i(low),
    .link(u_qdc_link_if), .active_code_o(acode), .active_span_o(aspan));

  qdc_link_asserts u_qdc_link_asserts (.clk_i(clk_i), .rst_i(rst_i),
    .sclk(u_qdc_link_if.sclk),
    .frame_select_load_n(u_qdc_link_if.frame_select_load_n),
    .serial_in(u_qdc_link_if.serial_in),
    .readback_out(u_qdc_link_if.readback_out),
    .readback_oe(u_qdc_link_if.readback_oe),
    .async_update_n(u_qdc_link_if.async_update_n),
    .system_clear_n(u_qdc_link_if.system_clear_n),
    .integrity_flag_n(u_qdc_link_if.integrity_flag_n));

  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  // Holds the request until ack is sampled, then releases it
  task automatic wb(input logic w, input logic [3:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) n_errors++;
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  // Busy poll leaves the readback word of the frame in rd
  task automatic frame(input logic [23:0] w);
    int n;
    logic [31:0] rb;
    n = 0;
    wb(1'b1, HREG_CMD, {8'h00, w});
    do begin
      wb(1'b0, HREG_RDATA, 32'h0);
      n++;
    end while (rd[16] !== 1'b0 && n < 500);
    if (n >= 500) n_errors++;
    rb = rd;
    repeat (10) @(posedge clk_i);
    rd = rb;
  endtask : frame

  task automatic t_reset;
    `CHK("code", 64'h0, acode)
    `CHK("span", 16'h0, aspan)
    wb(1'b0, HREG_STAT, 32'h0);
    `CHK("flag", 1'b0, rd[2])
  endtask : t_reset

  task automatic t_write_update;
    frame({CMD_WSPAN, ADDR_ALL, 16'h0003});
    frame({CMD_WSPAN, 4'h0, 16'h0001});
    `CHK("roll span", 16'h0003, rd[15:0])
    frame({CMD_WCODE, ADDR_ALL, 16'h8000});
    frame({CMD_WCODE, 4'h0, 16'h0000});
    `CHK("roll code", 16'h8000, rd[15:0])
    `CHK("held", 64'h0, acode)
    frame({CMD_UPD, ADDR_ALL, 16'ha5a5});
    `CHK("code", EXP_CODE, acode)
    `CHK("span", 16'h3331, aspan)
    wb(1'b0, HREG_STAT, 32'h0);
    `CHK("flag", 1'b1, rd[2])
  endtask : t_write_update

  task automatic t_long;
    wb(1'b1, HREG_CTRL, 32'h1);
    frame({CMD_RD_ISPAN, 4'h0, 16'h0000});
    `CHK("read span", 16'h0001, rd[15:0])
    wb(1'b1, HREG_CTRL, 32'h0);
  endtask : t_long

  task automatic t_clear;
    wb(1'b1, HREG_CTRL, 32'h4);
    repeat (10) @(posedge clk_i);
    `CHK("cleared", 64'h0, acode)
    wb(1'b0, HREG_STAT, 32'h0);
    `CHK("flag bits", 2'b01, rd[2:1])
    `CHK("irq", 1'b1, irq)
    wb(1'b1, HREG_STAT, 32'h0003_0000);
    repeat (2) @(posedge clk_i);
    `CHK("irq masked", 1'b0, irq)
    wb(1'b1, HREG_STAT, 32'h0000_0003);
    wb(1'b0, HREG_STAT, 32'h0);
    `CHK("sticky", 2'b00, rd[1:0])
    `CHK("irq cleared", 1'b0, irq)
    wb(1'b1, HREG_CTRL, 32'h0);
    wb(1'b1, HREG_CTRL, 32'h2);
    repeat (20) @(posedge clk_i);
    `CHK("restored", EXP_CODE, acode)
    `CHK("span", 16'h3331, aspan)
  endtask : t_clear

  task automatic t_manual;
    man <= 1'b1;
    strap <= 4'h4;
    frame({CMD_UPD, ADDR_ALL, 16'h0000});
    `CHK("strap span", 16'h4444, aspan)
    `CHK("code", EXP_CODE, acode)
    frame({CMD_RD_ASPAN, 4'h2, 16'h0000});
    `CHK("read strap", 16'h0004, rd[15:0])
  endtask : t_manual

  task automatic t_supply;
    low <= 1'b1;
    repeat (8) @(posedge clk_i);
    low <= 1'b0;
    wb(1'b0, HREG_STAT, 32'h0);
    `CHK("dip flag", 1'b0, rd[2])
    frame({CMD_UPD_ALL, ADDR_ALL, 16'h0000});
    wb(1'b0, HREG_STAT, 32'h0);
    `CHK("flag back", 1'b1, rd[2])
  endtask : t_supply

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_write_update();
    t_long();
    t_clear();
    t_manual();
    t_supply();
    stop_test();
  end

  // Whole run is near 2000 cycles; allow a wide margin
  initial begin
    #500000;
    n_errors++;
    stop_test();
  end
endmodule : quad_dac_command_reset_control_tb_top
